// ### logic/ubu_consts.svh
// Register offsets, field positions and reset values of the user break unit
`ifndef UBU_CONSTS_SVH
`define UBU_CONSTS_SVH

`define UBU_OFF_ORIGIN_TRACE 32'h0FFFFFAC
`define UBU_OFF_A_ADDR       32'h0FFFFFB0
`define UBU_OFF_A_MASK       32'h0FFFFFB4
`define UBU_OFF_A_CYCLE      32'h0FFFFFB8
`define UBU_OFF_TARGET_TRACE 32'h0FFFFFBC
`define UBU_OFF_B_SPACE_ID   32'h0FFFFFE8
`define UBU_OFF_B_DATA       32'hFFFFFF90
`define UBU_OFF_B_DMASK      32'hFFFFFF94
`define UBU_OFF_CONTROL      32'hFFFFFF98
`define UBU_OFF_COUNT        32'hFFFFFF9C
`define UBU_OFF_B_ADDR       32'hFFFFFFA0
`define UBU_OFF_B_MASK       32'hFFFFFFA4
`define UBU_OFF_B_CYCLE      32'hFFFFFFA8
`define UBU_OFF_A_SPACE_ID   32'hFFFFFFE4

`define UBU_RST_WORD   32'h00000000
`define UBU_RST_HALF   16'h0000

`define UBU_CTL_SEQ      0
`define UBU_CTL_A_CACHE  1
`define UBU_CTL_B_CACHE  2
`define UBU_CTL_BD_CACHE 3
`define UBU_CTL_A_AFTER  4
`define UBU_CTL_B_AFTER  5
`define UBU_CTL_CNT_EN   6
`define UBU_CTL_BD_EN    7
`define UBU_CTL_FLAG_B   14
`define UBU_CTL_FLAG_A   15

`define UBU_SID_EN       15
`define UBU_TRACE_VALID  31

`endif

// ### logic/ubu_pkg.sv
// Types shared by the user break unit
`default_nettype none
package ubu_pkg;
    typedef enum logic {UBU_SEQ_IDLE, UBU_SEQ_ARMED} ubu_seq_t;
    typedef logic [1:0] ubu_sel_t;
    typedef logic [31:0] ubu_word_t;
endpackage
`default_nettype wire

// ### logic/ubu_channel.sv
// One break comparison channel of the user break unit
`timescale 1ns/1ps
`default_nettype none
`include "ubu_consts.svh"
module ubu_channel #(
    parameter bit HAS_DATA = 1'b0
) (
    input  wire logic             i_bus_valid,
    input  wire logic             i_bus_dma,
    input  wire logic             i_bus_ifetch,
    input  wire logic             i_bus_write,
    input  wire ubu_pkg::ubu_sel_t i_bus_size,
    input  wire logic [7:0]       i_address_space_identifier,
    input  wire ubu_pkg::ubu_word_t i_cpu_addr,
    input  wire ubu_pkg::ubu_word_t i_cache_addr,
    input  wire ubu_pkg::ubu_word_t i_cpu_data,
    input  wire ubu_pkg::ubu_word_t i_cache_data,
    input  wire ubu_pkg::ubu_word_t i_match_addr,
    input  wire ubu_pkg::ubu_word_t i_addr_mask,
    input  wire logic [7:0]       i_cycle_sel,
    input  wire logic [15:0]      i_space_id,
    input  wire logic             i_addr_cache,
    input  wire ubu_pkg::ubu_word_t i_match_data,
    input  wire ubu_pkg::ubu_word_t i_data_mask,
    input  wire logic             i_data_cache,
    input  wire logic             i_data_en,
    output logic                  o_match
);
    import ubu_pkg::*;

    ubu_word_t addr;
    ubu_word_t data;
    ubu_sel_t  master_sel;
    ubu_sel_t  kind_sel;
    ubu_sel_t  dir_sel;
    ubu_sel_t  size_sel;
    logic      addr_ok;
    logic      address_space_identifier_ok;
    logic      data_ok;
    logic      master_ok;
    logic      kind_ok;
    logic      dir_ok;
    logic      size_ok;

    assign master_sel = i_cycle_sel[7:6];
    assign kind_sel   = i_cycle_sel[5:4];
    assign dir_sel    = i_cycle_sel[3:2];
    assign size_sel   = i_cycle_sel[1:0];

    // Address source select
    assign addr    = i_addr_cache ? i_cache_addr : i_cpu_addr;
    // Masked address compare, mask bit 1 drops the bit
    assign addr_ok = ((addr ^ i_match_addr) & ~i_addr_mask) == 32'h00000000;
    // Space identifier prefix extends the compare to 40 bits
    assign address_space_identifier_ok = !i_space_id[`UBU_SID_EN] || (i_space_id[7:0] == i_address_space_identifier);

    // Data compare exists only where HAS_DATA is set
    assign data    = i_data_cache ? i_cache_data : i_cpu_data;
    assign data_ok = !HAS_DATA || !i_data_en
                     || (((data ^ i_match_data) & ~i_data_mask) == 32'h00000000);

    // Bus master qualifier
    always_comb begin
        case (master_sel)
            2'b00:   master_ok = 1'b0;
            2'b10:   master_ok = i_bus_dma;
            default: master_ok = !i_bus_dma;
        endcase
    end

    // Cycle kind, direction and size qualifiers
    assign kind_ok = (kind_sel == 2'b00) || (kind_sel[0] && i_bus_ifetch)
                     || (kind_sel[1] && !i_bus_ifetch);
    assign dir_ok  = (dir_sel == 2'b00) || (dir_sel[0] && !i_bus_write)
                     || (dir_sel[1] && i_bus_write);
    assign size_ok = (size_sel == 2'b00) || (size_sel == i_bus_size);

    // All qualifiers judged on the same bus cycle
    assign o_match = i_bus_valid && master_ok && kind_ok && dir_ok && size_ok
                     && addr_ok && address_space_identifier_ok && data_ok;
endmodule
`default_nettype wire

// ### logic/ubu_top.sv
// User break unit top: APB registers, break sequencing, repeat count, branch trace
//
// Summary of operation
// - Two independent channels A and B, each with own address, mask, cycle settings.
// - Sequential mode breaks when A matches, then B in a later bus cycle.
// - Address compare spans a space identifier plus the 32-bit logical address.
// - Every one of the 32 address bits can be masked on its own.
// - Each channel picks processor or cache address bus for compare.
// - Only channel B compares a 32-bit data value under a per-bit mask.
// - Channel B picks processor or cache data bus for data compare.
// - Each channel qualifies by bus master: processor or DMA controller cycles.
// - Each channel qualifies by fetch versus data access and read versus write.
// - Each channel can qualify by byte, word or longword operand size.
// - A satisfied break condition raises a user break request.
// - Instruction fetch breaks are taken before or after execution, selectable.
// - Repeat count lets the channel B break fire after a programmed number of channel B matches.
// - Eight pairs of branch source and destination addresses kept for readback.
// - Break registers set by power-on reset and kept otherwise.
// - Trace bit 31 is a valid flag cleared by reset; other bits never reset.
// - Address mask bit 0 keeps the address bit compared, 1 excludes it.
// - Master select 00 disables, low bit set means processor, 10 means DMA.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ubu_consts.svh"
module ubu_top #(
    parameter int TRACE_DEPTH = 8,
    parameter int COUNT_W     = 12
) (
    input  wire logic               i_clk,
    input  wire logic               i_srst,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire ubu_pkg::ubu_word_t i_paddr,
    input  wire ubu_pkg::ubu_word_t i_pwdata,
    output logic [31:0]             o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    input  wire logic               i_bus_valid,
    input  wire logic               i_bus_dma,
    input  wire logic               i_bus_ifetch,
    input  wire logic               i_bus_write,
    input  wire ubu_pkg::ubu_sel_t  i_bus_size,
    input  wire logic [7:0]         i_address_space_identifier,
    input  wire ubu_pkg::ubu_word_t i_cpu_addr,
    input  wire ubu_pkg::ubu_word_t i_cache_addr,
    input  wire ubu_pkg::ubu_word_t i_cpu_data,
    input  wire ubu_pkg::ubu_word_t i_cache_data,
    input  wire logic               i_branch_valid,
    input  wire ubu_pkg::ubu_word_t i_branch_src,
    input  wire ubu_pkg::ubu_word_t i_branch_dst,
    output logic                    o_break_req,
    output logic                    o_break_after
);
    import ubu_pkg::*;

    localparam int PW = (TRACE_DEPTH > 1) ? $clog2(TRACE_DEPTH) : 1;

    typedef struct packed {
        ubu_word_t                      addr_a;
        ubu_word_t                      mask_a;
        ubu_word_t                      addr_b;
        ubu_word_t                      mask_b;
        ubu_word_t                      data_b;
        ubu_word_t                      dmask_b;
        ubu_word_t                      ctrl;
        logic [7:0]                     cyc_a;
        logic [7:0]                     cyc_b;
        logic [15:0]                    sid_a;
        logic [15:0]                    sid_b;
        logic [COUNT_W-1:0]             count;
        ubu_seq_t                       seq;
        logic [TRACE_DEPTH-1:0]         tvalid;
        logic [TRACE_DEPTH-1:0][30:0]   tsrc;
        logic [TRACE_DEPTH-1:0][30:0]   tdst;
        logic [PW-1:0]                  wptr;
        logic [PW-1:0]                  rptr;
        logic                           pready;
        logic                           pslverr;
        ubu_word_t                      prdata;
        logic                           brk;
        logic                           after;
    } ubu_state_t;

    ubu_state_t st_reg;
    ubu_state_t st_next;

    logic [1:0][31:0] cfg_addr;
    logic [1:0][31:0] cfg_mask;
    logic [1:0][7:0]  cfg_cyc;
    logic [1:0][15:0] cfg_sid;
    logic [1:0]       cfg_cache;
    logic [1:0]       ch_match;
    logic             access;
    logic             wr_en;

    assign cfg_addr  = {st_reg.addr_b, st_reg.addr_a};
    assign cfg_mask  = {st_reg.mask_b, st_reg.mask_a};
    assign cfg_cyc   = {st_reg.cyc_b, st_reg.cyc_a};
    assign cfg_sid   = {st_reg.sid_b, st_reg.sid_a};
    assign cfg_cache = {st_reg.ctrl[`UBU_CTL_B_CACHE], st_reg.ctrl[`UBU_CTL_A_CACHE]};
    assign access    = i_psel && i_penable;
    assign wr_en     = access && st_reg.pready && i_pwrite && !st_reg.pslverr;

    // Two comparison channels, data compare on channel B only
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            ubu_channel #(
                .HAS_DATA (g == 1)
            ) u_chan (
                .i_bus_valid  (i_bus_valid),
                .i_bus_dma    (i_bus_dma),
                .i_bus_ifetch (i_bus_ifetch),
                .i_bus_write  (i_bus_write),
                .i_bus_size   (i_bus_size),
                .i_address_space_identifier       (i_address_space_identifier),
                .i_cpu_addr   (i_cpu_addr),
                .i_cache_addr (i_cache_addr),
                .i_cpu_data   (i_cpu_data),
                .i_cache_data (i_cache_data),
                .i_match_addr (cfg_addr[g]),
                .i_addr_mask  (cfg_mask[g]),
                .i_cycle_sel  (cfg_cyc[g]),
                .i_space_id   (cfg_sid[g]),
                .i_addr_cache (cfg_cache[g]),
                .i_match_data (st_reg.data_b),
                .i_data_mask  (st_reg.dmask_b),
                .i_data_cache (st_reg.ctrl[`UBU_CTL_BD_CACHE]),
                .i_data_en    (st_reg.ctrl[`UBU_CTL_BD_EN]),
                .o_match      (ch_match[g])
            );
        end
    endgenerate

    always_comb begin
        logic        hit;
        ubu_word_t   rdata;
        logic        seq_mode;
        logic        cnt_en;
        logic        b_live;
        logic        b_hit;
        logic        fire;
        logic        from_b;
        logic        clr_a;
        logic        clr_b;
        hit      = 1'b1;
        rdata    = `UBU_RST_WORD;
        seq_mode = st_reg.ctrl[`UBU_CTL_SEQ];
        cnt_en   = st_reg.ctrl[`UBU_CTL_CNT_EN];
        b_live   = 1'b0;
        b_hit    = 1'b0;
        fire     = 1'b0;
        from_b   = 1'b0;
        clr_a    = 1'b0;
        clr_b    = 1'b0;
        st_next  = st_reg;

        // Register read decode, bits above each stored width read zero; stored reserved bits (control, space ID) read back as written
        case (i_paddr)
            `UBU_OFF_A_ADDR:       rdata = st_reg.addr_a;
            `UBU_OFF_A_MASK:       rdata = st_reg.mask_a;
            `UBU_OFF_A_CYCLE:      rdata = {24'h000000, st_reg.cyc_a};
            `UBU_OFF_B_ADDR:       rdata = st_reg.addr_b;
            `UBU_OFF_B_MASK:       rdata = st_reg.mask_b;
            `UBU_OFF_B_CYCLE:      rdata = {24'h000000, st_reg.cyc_b};
            `UBU_OFF_B_DATA:       rdata = st_reg.data_b;
            `UBU_OFF_B_DMASK:      rdata = st_reg.dmask_b;
            `UBU_OFF_CONTROL:      rdata = st_reg.ctrl;
            `UBU_OFF_COUNT:        rdata = {{(32 - COUNT_W){1'b0}}, st_reg.count};
            `UBU_OFF_A_SPACE_ID:   rdata = {16'h0000, st_reg.sid_a};
            `UBU_OFF_B_SPACE_ID:   rdata = {16'h0000, st_reg.sid_b};
            `UBU_OFF_ORIGIN_TRACE: rdata = {st_reg.tvalid[st_reg.rptr],
                                            st_reg.tsrc[st_reg.rptr]};
            `UBU_OFF_TARGET_TRACE: rdata = {st_reg.tvalid[st_reg.rptr],
                                            st_reg.tdst[st_reg.rptr]};
            default:               hit = 1'b0;
        endcase

        // APB slave, one wait state before pready
        if (access && !st_reg.pready) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = !hit;
            st_next.prdata  = i_pwrite ? `UBU_RST_WORD : rdata;
        end else begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
        end

        // Register writes at the completing edge
        if (wr_en) begin
            case (i_paddr)
                `UBU_OFF_A_ADDR:     st_next.addr_a  = i_pwdata;
                `UBU_OFF_A_MASK:     st_next.mask_a  = i_pwdata;
                `UBU_OFF_A_CYCLE:    st_next.cyc_a   = i_pwdata[7:0];
                `UBU_OFF_B_ADDR:     st_next.addr_b  = i_pwdata;
                `UBU_OFF_B_MASK:     st_next.mask_b  = i_pwdata;
                `UBU_OFF_B_CYCLE:    st_next.cyc_b   = i_pwdata[7:0];
                `UBU_OFF_B_DATA:     st_next.data_b  = i_pwdata;
                `UBU_OFF_B_DMASK:    st_next.dmask_b = i_pwdata;
                `UBU_OFF_COUNT:      st_next.count   = i_pwdata[COUNT_W-1:0];
                `UBU_OFF_A_SPACE_ID: st_next.sid_a   = i_pwdata[15:0];
                `UBU_OFF_B_SPACE_ID: st_next.sid_b   = i_pwdata[15:0];
                `UBU_OFF_CONTROL: begin
                    st_next.ctrl = i_pwdata;
                    clr_a        = !i_pwdata[`UBU_CTL_FLAG_A];
                    clr_b        = !i_pwdata[`UBU_CTL_FLAG_B];
                end
                default: ;
            endcase
        end
        st_next.ctrl[`UBU_CTL_FLAG_A] = (st_reg.ctrl[`UBU_CTL_FLAG_A] && !clr_a) || ch_match[0];
        st_next.ctrl[`UBU_CTL_FLAG_B] = (st_reg.ctrl[`UBU_CTL_FLAG_B] && !clr_b) || ch_match[1];

        // Trace readback pops the oldest pair after the target word is read
        if (access && st_reg.pready && !i_pwrite && !st_reg.pslverr
            && i_paddr == `UBU_OFF_TARGET_TRACE && st_reg.tvalid[st_reg.rptr]) begin
            st_next.tvalid[st_reg.rptr] = 1'b0;
            st_next.rptr = st_reg.rptr + 1'b1;
        end

        // Branch capture, overwriting the oldest pair when full
        if (i_branch_valid) begin
            st_next.tsrc[st_reg.wptr]   = i_branch_src[30:0];
            st_next.tdst[st_reg.wptr]   = i_branch_dst[30:0];
            st_next.tvalid[st_reg.wptr] = 1'b1;
            st_next.wptr = st_reg.wptr + 1'b1;
            if (st_reg.tvalid[st_reg.wptr] && st_reg.wptr == st_reg.rptr) begin
                st_next.rptr = st_reg.rptr + 1'b1;
            end
        end

        // Channel B matches count only when live for the current mode
        b_live = ch_match[1] && (!seq_mode || st_reg.seq == UBU_SEQ_ARMED);
        b_hit  = b_live && (!cnt_en || st_reg.count <= COUNT_W'(1));
        if (b_live && cnt_en && st_reg.count != '0 && !(wr_en && i_paddr == `UBU_OFF_COUNT)) begin
            st_next.count = st_reg.count - 1'b1;
        end

        // Sequential or independent break decision
        if (seq_mode) begin
            fire   = b_hit;
            from_b = b_hit;
            if (fire) begin
                st_next.seq = UBU_SEQ_IDLE;
            end
            if (ch_match[0]) begin
                st_next.seq = UBU_SEQ_ARMED;
            end
        end else begin
            fire        = ch_match[0] || b_hit;
            from_b      = b_hit;
            st_next.seq = UBU_SEQ_IDLE;
        end

        // Break request and its timing, data accesses always break after
        st_next.brk = fire;
        if (fire) begin
            if (!i_bus_ifetch) begin
                st_next.after = 1'b1;
            end else if (from_b) begin
                st_next.after = st_reg.ctrl[`UBU_CTL_B_AFTER];
            end else begin
                st_next.after = st_reg.ctrl[`UBU_CTL_A_AFTER];
            end
        end

        // Power-on reset, trace contents other than valid flags untouched
        if (i_srst) begin
            st_next         = '0;
            st_next.addr_a  = `UBU_RST_WORD;
            st_next.mask_a  = `UBU_RST_WORD;
            st_next.addr_b  = `UBU_RST_WORD;
            st_next.mask_b  = `UBU_RST_WORD;
            st_next.data_b  = `UBU_RST_WORD;
            st_next.dmask_b = `UBU_RST_WORD;
            st_next.ctrl    = `UBU_RST_WORD;
            st_next.sid_a   = `UBU_RST_HALF;
            st_next.sid_b   = `UBU_RST_HALF;
            st_next.tsrc    = st_reg.tsrc;
            st_next.tdst    = st_reg.tdst;
        end
    end

    always_ff @(posedge i_clk) begin
        st_reg <= st_next;
    end

    assign o_prdata      = st_reg.prdata;
    assign o_pready      = st_reg.pready;
    assign o_pslverr     = st_reg.pslverr;
    assign o_break_req   = st_reg.brk;
    assign o_break_after = st_reg.after;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_both_first;
        st_reg.ctrl[`UBU_CTL_SEQ] && st_reg.seq == UBU_SEQ_IDLE && ch_match[0] && ch_match[1];
    endsequence

    sequence s_armed_b;
        st_reg.ctrl[`UBU_CTL_SEQ] && !st_reg.ctrl[`UBU_CTL_CNT_EN]
        && st_reg.seq == UBU_SEQ_ARMED && ch_match[1];
    endsequence

    chk_seq_same_cycle: assert property (s_both_first |=> !o_break_req)
        else $error("sequential break fired on a same-cycle match");

    chk_seq_armed_fire: assert property (s_armed_b |=> o_break_req)
        else $error("armed sequential break missed channel B match");

    chk_indep_break: assert property (
        !st_reg.ctrl[`UBU_CTL_SEQ] && ch_match[0] |=> o_break_req)
        else $error("independent channel A match raised no break");

    chk_count_holdoff: assert property (
        !st_reg.ctrl[`UBU_CTL_SEQ] && st_reg.ctrl[`UBU_CTL_CNT_EN] && ch_match[1]
        && !ch_match[0] && st_reg.count > COUNT_W'(1) && !wr_en
        |=> !o_break_req && st_reg.count == $past(st_reg.count) - 1'b1)
        else $error("repeat count did not hold off and decrement");

    chk_after_timing: assert property (
        !st_reg.ctrl[`UBU_CTL_SEQ] && ch_match[0] && !ch_match[1] && i_bus_ifetch
        |=> o_break_after == $past(st_reg.ctrl[`UBU_CTL_A_AFTER]))
        else $error("break timing does not follow channel A setting");

    chk_mask_all: assert property (
        st_reg.mask_a == 32'hFFFFFFFF && st_reg.cyc_a == 8'h40 && !st_reg.sid_a[`UBU_SID_EN]
        && i_bus_valid && !i_bus_dma |-> ch_match[0])
        else $error("fully masked processor cycle did not match");

    chk_master_off: assert property (st_reg.cyc_b[7:6] == 2'b00 |-> !ch_match[1])
        else $error("channel B matched with master select off");

    chk_dma_only: assert property (
        st_reg.cyc_a[7:6] == 2'b10 && !i_bus_dma |-> !ch_match[0])
        else $error("DMA-only channel A matched a processor cycle");

    chk_trace_push: assert property (
        i_branch_valid |=> st_reg.tvalid[$past(st_reg.wptr)])
        else $error("branch capture left its entry invalid");

    chk_reset_clear: assert property (@(posedge i_clk) disable iff (1'b0)
        i_srst |=> st_reg.tvalid == '0 && st_reg.ctrl == `UBU_RST_WORD)
        else $error("reset left trace valid or control set");

    chk_apb_ready: assert property (access && !o_pready |=> o_pready ##1 !o_pready)
        else $error("APB ready not a single cycle after one wait");
endmodule
`default_nettype wire

// ### verification/ubu_bus_model.sv
// Partner model driving monitored processor and DMA bus cycles
`timescale 1ns/1ps
`default_nettype none
module ubu_bus_model (
    input  wire logic          i_clk,
    output logic               o_bus_valid,
    output logic               o_bus_dma,
    output logic               o_bus_ifetch,
    output logic               o_bus_write,
    output ubu_pkg::ubu_sel_t  o_bus_size,
    output logic [7:0]         o_address_space_identifier,
    output ubu_pkg::ubu_word_t o_cpu_addr,
    output ubu_pkg::ubu_word_t o_cache_addr,
    output ubu_pkg::ubu_word_t o_cpu_data,
    output ubu_pkg::ubu_word_t o_cache_data
);
    import ubu_pkg::*;
    initial begin
        {o_bus_valid, o_bus_dma, o_bus_ifetch, o_bus_write, o_bus_size, o_address_space_identifier} = '0;
        {o_cpu_addr, o_cache_addr, o_cpu_data, o_cache_data} = '0;
    end
    // One cycle; cache buses carry the inverse so a wrong source never matches
    task automatic cycle(input logic [2:0] k, input ubu_sel_t s, input logic [7:0] id,
                         input ubu_word_t a, input ubu_word_t d);
        @(posedge i_clk);
        {o_bus_valid, o_bus_dma, o_bus_ifetch, o_bus_write, o_bus_size, o_address_space_identifier} <=
            {1'b1, k, s, id};
        {o_cpu_addr, o_cache_addr, o_cpu_data, o_cache_data} <= {a, ~a, d, ~d};
        @(posedge i_clk);
        o_bus_valid <= 1'b0;
        // Released buses flip
        {o_cpu_addr, o_cache_addr, o_cpu_data, o_cache_data} <= {~a, a, ~d, d};
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench of the user break unit
`timescale 1ns/1ps
`default_nettype none
`include "ubu_consts.svh"
module testbench;
    import ubu_pkg::*;
    logic        i_clk, i_srst, i_psel, i_penable, i_pwrite, i_branch_valid;
    logic        i_bus_valid, i_bus_dma, i_bus_ifetch, i_bus_write, err;
    logic        o_pready, o_pslverr, o_break_req, o_break_after;
    ubu_sel_t    i_bus_size;
    logic [7:0]  i_address_space_identifier;
    logic [31:0] o_prdata;
    ubu_word_t   i_paddr, i_pwdata, i_branch_src, i_branch_dst, rd;
    ubu_word_t   i_cpu_addr, i_cache_addr, i_cpu_data, i_cache_data;
    int          failures, n_compared, cycles;
    ubu_word_t   rst_addr [10] = '{`UBU_OFF_A_ADDR, `UBU_OFF_A_MASK, `UBU_OFF_A_CYCLE,
        `UBU_OFF_B_DATA, `UBU_OFF_B_DMASK, `UBU_OFF_CONTROL, `UBU_OFF_COUNT,
        `UBU_OFF_B_ADDR, `UBU_OFF_B_MASK, `UBU_OFF_B_CYCLE};
    ubu_top dut_u (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_bus_valid, .i_bus_dma, .i_bus_ifetch,
        .i_bus_write, .i_bus_size, .i_address_space_identifier, .i_cpu_addr, .i_cache_addr, .i_cpu_data,
        .i_cache_data, .i_branch_valid, .i_branch_src, .i_branch_dst, .o_break_req,
        .o_break_after);
    ubu_bus_model bus_u (.i_clk, .o_bus_valid(i_bus_valid), .o_bus_dma(i_bus_dma),
        .o_bus_ifetch(i_bus_ifetch), .o_bus_write(i_bus_write), .o_bus_size(i_bus_size),
        .o_address_space_identifier(i_address_space_identifier), .o_cpu_addr(i_cpu_addr), .o_cache_addr(i_cache_addr),
        .o_cpu_data(i_cpu_data), .o_cache_data(i_cache_data));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic give_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic cmp_word(input ubu_word_t got, input ubu_word_t exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input ubu_word_t a, input ubu_word_t d = 32'h0);
        @(posedge i_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, wr, a, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask
    task automatic rd_chk(input ubu_word_t a, input ubu_word_t exp);
        apb(1'b0, a);
        cmp_word(rd, exp);
        cmp_bit(err, 1'b0);
    endtask
    task automatic brk(input logic exp, input logic [2:0] k, input ubu_sel_t s,
                       input logic [7:0] id = 8'h05, input ubu_word_t a = 32'h12345ABC,
                       input ubu_word_t d = 32'h0);
        bus_u.cycle(k, s, id, a, d);
        #1;
        cmp_bit(o_break_req, exp);
    endtask
    task automatic branch(input ubu_word_t s, input ubu_word_t d);
        @(posedge i_clk);
        {i_branch_valid, i_branch_src, i_branch_dst} <= {1'b1, s, d};
        @(posedge i_clk);
        i_branch_valid <= 1'b0;
    endtask
    initial begin
        {i_srst, i_psel, i_penable, i_pwrite, i_branch_valid} = 5'b10000;
        {i_paddr, i_pwdata, i_branch_src, i_branch_dst} = '0;
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        foreach (rst_addr[i]) rd_chk(rst_addr[i], 32'h0);
        apb(1'b0, `UBU_OFF_TARGET_TRACE);
        cmp_bit(rd[31], 1'b0);
        apb(1'b0, 32'h00000100);
        cmp_bit(err, 1'b1);
        apb(1'b1, `UBU_OFF_A_ADDR, 32'h12345000);
        apb(1'b1, `UBU_OFF_A_MASK, 32'h00000FFF);
        apb(1'b1, `UBU_OFF_A_SPACE_ID, 32'h00008005);
        apb(1'b1, `UBU_OFF_A_CYCLE, 32'h00000055);
        rd_chk(`UBU_OFF_A_MASK, 32'h00000FFF);
        brk(1'b1, 3'b010, 2'b01);
        cmp_bit(o_break_after, 1'b0);
        brk(1'b0, 3'b010, 2'b10);
        brk(1'b0, 3'b010, 2'b01, 8'h06);
        brk(1'b0, 3'b010, 2'b01, 8'h05, 32'h12346ABC);
        brk(1'b0, 3'b000, 2'b01);
        brk(1'b0, 3'b011, 2'b01);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `UBU_OFF_A_CYCLE, {24'h0, 2'(m), 6'h15});
            brk(m[0], 3'b010, 2'b01);
            brk(m == 2, 3'b110, 2'b01);
        end
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000012);
        brk(1'b0, 3'b010, 2'b01);
        brk(1'b1, 3'b010, 2'b01, 8'h05, 32'hEDCBA543);
        cmp_bit(o_break_after, 1'b1);
        apb(1'b1, `UBU_OFF_A_CYCLE, 32'h0);
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000080);
        apb(1'b1, `UBU_OFF_B_ADDR, 32'hABCD0000);
        apb(1'b1, `UBU_OFF_B_CYCLE, 32'h000000AB);
        apb(1'b1, `UBU_OFF_B_DATA, 32'hCAFE0000);
        apb(1'b1, `UBU_OFF_B_DMASK, 32'h0000FFFF);
        brk(1'b1, 3'b101, 2'b11, 8'h00, 32'hABCD0000, 32'hCAFE1234);
        cmp_bit(o_break_after, 1'b1);
        brk(1'b0, 3'b101, 2'b11, 8'h00, 32'hABCD0000, 32'hCAFF1234);
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000088);
        brk(1'b0, 3'b101, 2'b11, 8'h00, 32'hABCD0000, 32'hCAFE1234);
        brk(1'b1, 3'b101, 2'b11, 8'h00, 32'hABCD0000, 32'h3501EDCB);
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000040);
        apb(1'b1, `UBU_OFF_COUNT, 32'h00000003);
        for (int i = 0; i < 3; i++) brk(i == 2, 3'b101, 2'b11, 8'h00, 32'hABCD0000);
        rd_chk(`UBU_OFF_COUNT, 32'h0);
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000001);
        apb(1'b1, `UBU_OFF_A_CYCLE, 32'h00000055);
        apb(1'b1, `UBU_OFF_B_ADDR, 32'h12345000);
        apb(1'b1, `UBU_OFF_B_MASK, 32'h00000FFF);
        apb(1'b1, `UBU_OFF_B_CYCLE, 32'h00000055);
        brk(1'b0, 3'b010, 2'b01);
        brk(1'b1, 3'b010, 2'b01);
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000025);
        brk(1'b0, 3'b010, 2'b01);
        brk(1'b1, 3'b010, 2'b01, 8'h05, 32'hEDCBA543);
        cmp_bit(o_break_after, 1'b1);
        apb(1'b1, `UBU_OFF_CONTROL, 32'h00000000);
        apb(1'b1, `UBU_OFF_A_MASK, 32'hFFFFFFFF);
        apb(1'b1, `UBU_OFF_A_SPACE_ID, 32'h00000000);
        apb(1'b1, `UBU_OFF_A_CYCLE, 32'h00000040);
        brk(1'b1, 3'b001, 2'b10, 8'h33, 32'h00000000);
        for (int i = 0; i < 8; i++) branch(32'hFFFF0100 + 32'(i), 32'h200 + 32'(i));
        for (int i = 0; i < 8; i++) begin
            rd_chk(`UBU_OFF_ORIGIN_TRACE, 32'hFFFF0100 + 32'(i));
            rd_chk(`UBU_OFF_TARGET_TRACE, 32'h80000200 + 32'(i));
        end
        apb(1'b0, `UBU_OFF_ORIGIN_TRACE);
        cmp_bit(rd[31], 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
